// file: hw/ncoos_top.sv
// Functional notes
// RULE1: each nco tick adds increment to 20-bit accumulator; carry is overflow.
// RULE2: 16-bit increment held as low byte and high byte registers.
// RULE3: low write loads buffer on second nco edge if enabled, else immediately.
// RULE4: toggle mode inverts output on every overflow, giving square wave.
// RULE5: pulse-mode select bit zero selects toggle mode.
// RULE6: pulse mode holds output active for selected periods, then inactive.
// RULE7: pulse turns active on first nco edge after overflow.
// RULE8: pulse-mode select bit one selects pulse mode.
// RULE9: width field bits 7..5 gives 2**value nco periods, 1 to 128.
// RULE10: width field has no effect in toggle mode.
// RULE11: software keeps pulse width below overflow period.
// RULE12: polarity bit 4 inverts final output; zero means active high.
// RULE13: polarity change with interrupts enabled raises the interrupt flag.
// RULE14: control bit 5 mirrors output level, read only.
// RULE15: pin driven only while output enable bit 6 is one.
// RULE16: final output goes to logic cell and waveform generator.
// RULE17: every overflow sets the interrupt flag.
// RULE18: request needs module, module irq, peripheral and global enables.
// RULE19: flag stays set until software writes zero.
// RULE20: reset clears every register to zero.
// RULE21: counting continues during sleep while source clock runs.
// RULE22: enabled with internal oscillator selected keeps that oscillator running.
// RULE23: clock field bits 1..0: pin, logic cell, system clock, internal oscillator.
// RULE24: disabled module holds accumulator, makes no overflows, output inactive.
// RULE25: control writes pass into nco tick timing before acting; a disable, the output enable and changes while disabled act at once.
`timescale 1ns/1ns
module ncoos_top
  import ncoos_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [ncoos_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ncoos_pkg::AXI_DW-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ncoos_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [ncoos_pkg::AXI_DW-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // clock sources
  input wire logic internal_hf_oscillator,
  input wire logic logic_cell1_output,
  input wire logic external_clock_pin,
  // outputs
  output logic nco_pin_o,
  output logic nco_pin_oe,
  output logic to_configurable_logic_cell,
  output logic to_complementary_waveform_gen,
  output logic overflow_interrupt_event,
  output logic hf_oscillator_keep_on
);
  import ncoos_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] ctrl_q;
  logic [7:0] clk_q;
  logic [7:0] inc_lo_q;
  logic [7:0] inc_hi_q;
  logic [INC_W-1:0] inc_buf_q;
  logic [ACC_W-1:0] acc_q;
  logic irq_flag_q;
  logic irq_ie_q;
  logic irq_peripheral_irq_enable_q;
  logic irq_gie_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic src_prev_q;
  logic en_s_q;
  logic pfm_s_q;
  logic pol_s_q;
  logic [2:0] pws_s_q;
  logic carry_q;
  logic [1:0] tick_cnt_q;
  ncoos_inc_st_t inc_st_q;
  logic wr_fire;
  logic wr_lo;
  logic tick;
  logic src_sel;
  logic [ACC_W:0] sum;
  logic pol_irq;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;
  logic out_level;
  ncoos_out_if oif();

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken together, one response outstanding
  assign awready = awvalid && wvalid && !bvalid_q;
  assign wready = awready;
  assign wr_fire = awready;
  assign wr_lo = wr_fire && wstrb[0];
  assign wr_hit = awaddr[1:0] == 2'h0 && awaddr <= OFF_IRQ;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid_q <= 1'b0;
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  // read channel: one read at a time, data registered
  assign arready = arvalid && !rvalid_q;

  always_comb
  begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (araddr)
      OFF_CTRL: rd_word[7:0] = {ctrl_q[7:6], out_level, ctrl_q[4:0]}; // see RULE14
      OFF_CLK: rd_word[7:0] = clk_q;
      OFF_ACC_LO: rd_word[7:0] = acc_q[7:0];
      OFF_ACC_HI: rd_word[7:0] = acc_q[15:8];
      OFF_ACC_UP: rd_word[7:0] = {4'h0, acc_q[19:16]};
      OFF_INC_LO: rd_word[7:0] = inc_lo_q;
      OFF_INC_HI: rd_word[7:0] = inc_hi_q;
      OFF_IRQ: rd_word[7:0] = {4'h0, irq_gie_q, irq_peripheral_irq_enable_q, irq_ie_q, irq_flag_q};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else if (arready)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready)
      rvalid_q <= 1'b0;
  end

  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // control and configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= REG_RESET; // see RULE20
      clk_q <= REG_RESET;
      inc_lo_q <= REG_RESET;
      inc_hi_q <= REG_RESET;
      irq_ie_q <= 1'b0;
      irq_peripheral_irq_enable_q <= 1'b0;
      irq_gie_q <= 1'b0;
    end
    else if (wr_lo)
    begin
      unique case (awaddr)
        OFF_CTRL: ctrl_q <= wdata[7:0] & CTRL_WR_MASK; // see RULE14
        OFF_CLK: clk_q <= wdata[7:0] & CLK_WR_MASK;
        OFF_INC_LO: inc_lo_q <= wdata[7:0]; // see RULE2
        OFF_INC_HI: inc_hi_q <= wdata[7:0];
        OFF_IRQ:
        begin
          irq_ie_q <= wdata[IRQ_IE_BIT];
          irq_peripheral_irq_enable_q <= wdata[IRQ_PERIPHERAL_IRQ_ENABLE_BIT];
          irq_gie_q <= wdata[IRQ_GIE_BIT];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // nco clock: rising edge of the selected source as a one-cycle enable
  always_comb
  begin
    unique case (clk_q[CLK_CKS_LSB +: 2]) // see RULE23
      CKS_HFOSC: src_sel = internal_hf_oscillator;
      CKS_SYSCLK: src_sel = 1'b1;
      CKS_LC1: src_sel = logic_cell1_output;
      CKS_PIN: src_sel = external_clock_pin;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      src_prev_q <= 1'b0;
    else
      src_prev_q <= src_sel;
  end

  // system clock source ticks every cycle
  assign tick = clk_q[CLK_CKS_LSB +: 2] == CKS_SYSCLK || (src_sel && !src_prev_q);

  // settings copied on nco edges; a disable acts at once
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_s_q <= 1'b0;
      pfm_s_q <= 1'b0;
      pol_s_q <= 1'b0;
      pws_s_q <= 3'h0;
    end
    else if (tick || !ctrl_q[CTRL_EN_BIT])
    begin
      en_s_q <= ctrl_q[CTRL_EN_BIT]; // see RULE25
      pfm_s_q <= ctrl_q[CTRL_PFM_BIT]; // see RULE5 see RULE8
      pol_s_q <= ctrl_q[CTRL_POL_BIT];
      pws_s_q <= clk_q[CLK_PWS_LSB +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // increment buffer load
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      inc_st_q <= INC_IDLE;
      tick_cnt_q <= 2'h0;
      inc_buf_q <= 16'h0000;
    end
    else if (!ctrl_q[CTRL_EN_BIT])
    begin
      inc_st_q <= INC_IDLE;
      tick_cnt_q <= 2'h0;
      inc_buf_q <= {inc_hi_q, inc_lo_q}; // see RULE3
    end
    else
    begin
      unique case (inc_st_q)
        INC_IDLE:
          if (wr_lo && awaddr == OFF_INC_LO)
          begin
            inc_st_q <= INC_ARMED;
            tick_cnt_q <= 2'h0;
          end
        INC_ARMED:
          if (tick && tick_cnt_q + 2'h1 == INC_LOAD_TICKS)
          begin
            inc_st_q <= INC_IDLE;
            inc_buf_q <= {inc_hi_q, inc_lo_q}; // see RULE3
          end
          else if (tick)
            tick_cnt_q <= tick_cnt_q + 2'h1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator; software byte writes take priority over a tick
  assign sum = {1'b0, acc_q} + {5'h00, inc_buf_q};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc_q <= 20'h00000;
      carry_q <= 1'b0;
    end
    else
    begin
      carry_q <= 1'b0;
      if (wr_lo && awaddr == OFF_ACC_LO)
        acc_q[7:0] <= wdata[7:0];
      else if (wr_lo && awaddr == OFF_ACC_HI)
        acc_q[15:8] <= wdata[7:0];
      else if (wr_lo && awaddr == OFF_ACC_UP)
        acc_q[19:16] <= wdata[3:0];
      else if (tick && en_s_q)
      begin
        acc_q <= sum[ACC_W-1:0]; // see RULE1 see RULE21
        carry_q <= sum[ACC_W]; // see RULE24
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output stage
  assign oif.tick = tick;
  assign oif.carry = carry_q;
  assign oif.enable = en_s_q;
  assign oif.pulse_mode = pfm_s_q;
  assign oif.polarity = pol_s_q;
  assign oif.width_sel = pws_s_q;
  assign out_level = oif.out_level;

  ncoos_out_stage u_stage (
    .aclk(aclk),
    .aresetn(aresetn),
    .io(oif.stage)
  );

  // final output to pin and on-chip users
  assign nco_pin_o = ctrl_q[CTRL_OE_BIT] && out_level; // see RULE15
  assign nco_pin_oe = ctrl_q[CTRL_OE_BIT]; // see RULE15
  assign to_configurable_logic_cell = out_level; // see RULE16
  assign to_complementary_waveform_gen = out_level; // see RULE16
  assign hf_oscillator_keep_on = ctrl_q[CTRL_EN_BIT] && clk_q[CLK_CKS_LSB +: 2] == CKS_HFOSC; // see RULE22

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flag and request; a set wins over a clear
  logic pol_prev_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pol_prev_q <= 1'b0;
    else
      pol_prev_q <= pol_s_q;
  end

  assign pol_irq = pol_s_q != pol_prev_q && irq_ie_q && irq_peripheral_irq_enable_q && irq_gie_q; // see RULE13

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_flag_q <= 1'b0;
    else if (carry_q || pol_irq)
      irq_flag_q <= 1'b1; // see RULE17
    else if (wr_lo && awaddr == OFF_IRQ && !wdata[IRQ_IF_BIT])
      irq_flag_q <= 1'b0; // see RULE19
  end

  assign overflow_interrupt_event = irq_flag_q && ctrl_q[CTRL_EN_BIT] && irq_ie_q && irq_peripheral_irq_enable_q
    && irq_gie_q; // see RULE18

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_carry_sets_flag: assert property (carry_q |=> irq_flag_q) // see RULE17
    else $error("overflow did not set flag");
  chk_flag_sticky: assert property (irq_flag_q && !(wr_lo && awaddr == OFF_IRQ) |=> irq_flag_q) // see RULE19
    else $error("flag cleared without a write");
  chk_irq_gate: assert property (overflow_interrupt_event |-> irq_flag_q && ctrl_q[CTRL_EN_BIT] && irq_gie_q) // see RULE18
    else $error("request without all enables");
  chk_acc_frozen: assert property (!en_s_q && !wr_lo |=> $stable(acc_q) && !carry_q) // see RULE24
    else $error("disabled accumulator moved");
  chk_acc_adds: assert property (tick && en_s_q && !wr_lo |=> acc_q == $past(sum[ACC_W-1:0])) // see RULE1
    else $error("accumulator did not add increment");
  chk_inc_now: assert property (!ctrl_q[CTRL_EN_BIT] ##1 !ctrl_q[CTRL_EN_BIT]
    |-> inc_buf_q == $past({inc_hi_q, inc_lo_q})) // see RULE3
    else $error("disabled increment load not immediate");
  chk_mirror_read: assert property (arready && araddr == OFF_CTRL |=> rdata_q[CTRL_OUT_BIT] == $past(out_level)) // see RULE14
    else $error("mirror bit wrong");
  chk_pin_gated: assert property (!ctrl_q[CTRL_OE_BIT] |-> !nco_pin_oe && !nco_pin_o) // see RULE15
    else $error("pin driven while disabled");
  chk_bvalid_hold: assert property (bvalid_q && !bready |=> bvalid_q && $stable(bresp_q))
    else $error("write response dropped");
  cov_irq: cover property ($rose(overflow_interrupt_event));
  cov_inc_armed: cover property (inc_st_q == INC_ARMED ##[1:20] inc_st_q == INC_IDLE);
  cov_pol_irq: cover property (pol_irq);

endmodule

// file: hw/ncoos_pkg.sv
package ncoos_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int ACC_W = 20;
  localparam int INC_W = 16;
  localparam int CNT_W = 8;
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CLK = 8'h04;
  localparam logic [7:0] OFF_ACC_LO = 8'h08;
  localparam logic [7:0] OFF_ACC_HI = 8'h0c;
  localparam logic [7:0] OFF_ACC_UP = 8'h10;
  localparam logic [7:0] OFF_INC_LO = 8'h14;
  localparam logic [7:0] OFF_INC_HI = 8'h18;
  localparam logic [7:0] OFF_IRQ = 8'h1c;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_OE_BIT = 6;
  localparam int CTRL_OUT_BIT = 5;
  localparam int CTRL_POL_BIT = 4;
  localparam int CTRL_PFM_BIT = 0;
  localparam int CLK_PWS_LSB = 5;
  localparam int CLK_CKS_LSB = 0;
  localparam int IRQ_IF_BIT = 0;
  localparam int IRQ_IE_BIT = 1;
  localparam int IRQ_PERIPHERAL_IRQ_ENABLE_BIT = 2;
  localparam int IRQ_GIE_BIT = 3;
  localparam logic [7:0] CTRL_WR_MASK = 8'hd1;
  localparam logic [7:0] CLK_WR_MASK = 8'he3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and codes
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] CKS_HFOSC = 2'h0;
  localparam logic [1:0] CKS_SYSCLK = 2'h1;
  localparam logic [1:0] CKS_LC1 = 2'h2;
  localparam logic [1:0] CKS_PIN = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // timing counts in nco clock ticks
  localparam logic [1:0] INC_LOAD_TICKS = 2'h2;

  typedef enum logic {INC_IDLE, INC_ARMED} ncoos_inc_st_t;

endpackage

// file: hw/ncoos_out_if.sv
`timescale 1ns/1ns
interface ncoos_out_if;
  logic tick;
  logic carry;
  logic enable;
  logic pulse_mode;
  logic polarity;
  logic [2:0] width_sel;
  logic out_level;

  // control end drives settings and events, stage end returns the output
  modport ctl (output tick, output carry, output enable, output pulse_mode,
               output polarity, output width_sel, input out_level);
  modport stage (input tick, input carry, input enable, input pulse_mode,
                 input polarity, input width_sel, output out_level);
endinterface

// file: hw/ncoos_out_stage.sv
`timescale 1ns/1ns
module ncoos_out_stage
  import ncoos_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // settings and events
  ncoos_out_if.stage io
);

  logic raw_q;
  logic pend_q;
  logic [CNT_W-1:0] cnt_q;
  logic out_q;
  logic pend;

  // an overflow in the same cycle as a tick counts as pending
  assign pend = pend_q | io.carry;

  ////////////////////////////////////////////////////////////////////////////
  // overflow waiting for the next nco edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !io.enable)
      pend_q <= 1'b0;
    else if (io.tick)
      pend_q <= 1'b0;
    else if (io.carry)
      pend_q <= 1'b1;
  end

  // raw waveform: toggle or stretched pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !io.enable)
    begin
      raw_q <= 1'b0; // see RULE24
      cnt_q <= '0;
    end
    else if (!io.pulse_mode)
    begin
      cnt_q <= '0;
      if (io.carry)
        raw_q <= ~raw_q; // see RULE4 see RULE10
    end
    else if (io.tick)
    begin
      if (pend)
      begin
        raw_q <= 1'b1; // see RULE6 see RULE7
        cnt_q <= (8'h01 << io.width_sel) - 8'h01; // see RULE9
      end
      else if (raw_q && cnt_q == '0)
        raw_q <= 1'b0; // see RULE6
      else if (raw_q)
        cnt_q <= cnt_q - 8'h01;
    end
  end

  // polarity is the last stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      out_q <= 1'b0;
    else
      out_q <= raw_q ^ io.polarity; // see RULE12
  end

  assign io.out_level = out_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_toggle_flip: assert property (io.enable && !io.pulse_mode && io.carry |=> raw_q != $past(raw_q)) // see RULE4
    else $error("toggle mode missed an overflow");
  chk_pulse_start: assert property (io.enable && io.pulse_mode && io.tick && pend |=> raw_q) // see RULE7
    else $error("pulse did not start on nco edge");
  chk_pulse_end: assert property (io.enable && io.pulse_mode && io.tick && !pend && raw_q && cnt_q == '0
    |=> !raw_q) // see RULE6
    else $error("pulse did not end after its width");
  chk_idle_low: assert property (!io.enable |=> !raw_q ##1 out_q == $past(io.polarity)) // see RULE24
    else $error("disabled output not inactive");
  cov_pulse: cover property (io.pulse_mode && $rose(raw_q));
  cov_toggle: cover property (!io.pulse_mode && $fell(raw_q));

endmodule

// file: tb/ncoos_far_model.sv
`timescale 1ns/1ns
// far side: free-running clock sources for the nco, levels synchronous to aclk
module ncoos_far_model
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // clock sources
  output logic internal_hf_oscillator,
  output logic logic_cell1_output,
  output logic external_clock_pin
);
  logic [4:0] div_q;

  ////////////////////////////////////////////////////////////////////////////
  // divider wraps at 30 so all three periods stay exact; never stops in sleep
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_q <= 5'h00;
    else if (div_q == 5'h1d)
      div_q <= 5'h00;
    else
      div_q <= div_q + 5'h01;
  end

  // sources with periods of 2, 3 and 5 clock cycles
  assign internal_hf_oscillator = div_q[0];
  assign logic_cell1_output = (div_q % 5'h03) == 5'h00;
  assign external_clock_pin = (div_q % 5'h05) < 5'h02;
endmodule

// file: tb/ncoos_top_test.sv
`timescale 1ns/1ns
// self-checking bench for the nco top level
module ncoos_top_test;
  import ncoos_pkg::*;
  logic aclk;
  logic aresetn;
  logic [AXI_AW-1:0] awaddr;
  logic awvalid;
  logic awready;
  logic [AXI_DW-1:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [AXI_AW-1:0] araddr;
  logic arvalid;
  logic arready;
  logic [AXI_DW-1:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  logic hf_src;
  logic cell_src;
  logic pin_src;
  logic pin_o;
  logic pin_oe;
  logic out_cell;
  logic out_wave;
  logic irq_event;
  logic keep_on;
  int fail_count;
  int compares;

  ////////////////////////////////////////////////////////////////////////////
  // design and far side
  ncoos_top DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .internal_hf_oscillator(hf_src), .logic_cell1_output(cell_src),
    .external_clock_pin(pin_src), .nco_pin_o(pin_o), .nco_pin_oe(pin_oe),
    .to_configurable_logic_cell(out_cell), .to_complementary_waveform_gen(out_wave),
    .overflow_interrupt_event(irq_event), .hf_oscillator_keep_on(keep_on));
  ncoos_far_model u_far (.aclk(aclk), .aresetn(aresetn), .internal_hf_oscillator(hf_src),
    .logic_cell1_output(cell_src), .external_clock_pin(pin_src));

  ////////////////////////////////////////////////////////////////////////////
  // reporting
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one step of a bounded wait, sampled where inputs are settled
  task automatic step(inout int i);
    @(negedge aclk);
    i++;
    if (i > 2000)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, i, 0);
      give_verdict();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite master
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    int i;
    i = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do step(i); while (!awready);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do step(i); while (!bvalid);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    i = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do step(i); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do step(i); while (!rvalid);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    check(32'(r), 32'(RESP_OKAY));
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    check(d, {24'h0, e});
    check(32'(r), 32'(RESP_OKAY));
  endtask

  // cycles spent in the second full stretch at level lvl on the logic cell feed
  task automatic meas(input logic lvl, output int n);
    int i;
    i = 0;
    n = 0;
    // skip two stretches so a source or width change just before cannot bend the one counted
    for (int s = 0; s < 2; s++)
    begin
      do step(i); while (out_cell === lvl);
      do step(i); while (out_cell !== lvl);
    end
    while (out_cell === lvl)
    begin
      step(i);
      n++;
    end
    check(32'(out_wave), 32'(out_cell));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    for (int k = 0; k < 8; k++)
      rd_chk(8'(k * 4), REG_RESET);
    check(32'({pin_o, pin_oe, out_cell, irq_event}), 32'h0);
    axi_rd(8'h20, d, r);
    check(d, 32'h0);
    check(32'(r), 32'(RESP_SLVERR));
    axi_wr(8'h24, 8'hff, r);
    check(32'(r), 32'(RESP_SLVERR));
    $display("test reset done");
  endtask

  task automatic t_access();
    wr(OFF_CTRL, 8'hef);
    rd_chk(OFF_CTRL, 8'hc1);
    check(32'(pin_oe), 32'h1);
    wr(OFF_CLK, 8'hff);
    rd_chk(OFF_CLK, 8'he3);
    wr(OFF_CTRL, 8'h00);
    wr(OFF_CLK, {6'h0, CKS_SYSCLK});
    $display("test access done");
  endtask

  task automatic t_idle();
    wr(OFF_CTRL, 8'h50);
    wr(OFF_INC_HI, 8'h80);
    wr(OFF_ACC_LO, 8'h5a);
    wr(OFF_ACC_HI, 8'ha5);
    rd_chk(OFF_ACC_LO, 8'h5a);
    rd_chk(OFF_ACC_HI, 8'ha5);
    rd_chk(OFF_CTRL, 8'h70);
    check(32'({pin_o, out_cell}), 32'h3);
    wr(OFF_CTRL, 8'h10);
    rd_chk(OFF_CTRL, 8'h30);
    check(32'({pin_o, pin_oe}), 32'h0);
    $display("test idle done");
  endtask

  task automatic t_toggle();
    int n;
    int per [4] = '{2, 1, 3, 5};
    wr(OFF_INC_LO, 8'h00);
    wr(OFF_CTRL, 8'h80);
    for (int k = 0; k < 4; k++)
    begin
      wr(OFF_CLK, {3'h7, 3'h0, 2'(k)});
      meas(1'b1, n);
      check(32'(n), 32'(32 * per[k]));
      meas(1'b0, n);
      check(32'(n), 32'(32 * per[k]));
      check(32'(keep_on), 32'(k == 0));
    end
    rd_chk(OFF_IRQ, 8'h01);
    $display("test toggle done");
  endtask

  task automatic t_pulse();
    int n;
    wr(OFF_CTRL, 8'h00);
    wr(OFF_INC_HI, 8'h10);
    wr(OFF_CTRL, 8'h81);
    for (int w = 0; w < 8; w++)
    begin
      wr(OFF_CLK, {3'(w), 3'h0, CKS_SYSCLK});
      meas(1'b1, n);
      check(32'(n), 32'(1 << w));
    end
    wr(OFF_CTRL, 8'h91);
    meas(1'b0, n);
    check(32'(n), 32'h80);
    $display("test pulse done");
  endtask

  task automatic t_irq();
    wr(OFF_CTRL, 8'h00);
    rd_chk(OFF_IRQ, 8'h01);
    wr(OFF_INC_HI, 8'h00);
    wr(OFF_CTRL, 8'h80);
    for (int m = 0; m < 8; m++)
    begin
      wr(OFF_IRQ, {4'h0, 3'(m), 1'b1});
      rd_chk(OFF_IRQ, {4'h0, 3'(m), 1'b1});
      check(32'(irq_event), 32'(m == 7));
    end
    wr(OFF_CTRL, 8'h00);
    check(32'(irq_event), 32'h0);
    wr(OFF_IRQ, 8'h0e);
    rd_chk(OFF_IRQ, 8'h0e);
    wr(OFF_CTRL, 8'h80);
    wr(OFF_CTRL, 8'h90);
    rd_chk(OFF_IRQ, 8'h0f);
    check(32'(irq_event), 32'h1);
    // enabled low write: buffer loads on the second tick, adding starts the tick after
    wr(OFF_ACC_LO, 8'h00);
    wr(OFF_ACC_HI, 8'h00);
    wr(OFF_ACC_UP, 8'h00);
    wr(OFF_INC_LO, 8'h01);
    rd_chk(OFF_ACC_LO, 8'h00);
    rd_chk(OFF_ACC_LO, 8'h03);
    $display("test irq done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // reset, scenarios and verdict
  initial
  begin
    fail_count = 0;
    compares = 0;
    aresetn = 1'b0;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_access();
    t_idle();
    t_toggle();
    t_pulse();
    t_irq();
    give_verdict();
  end
endmodule
